// >>> rtl/ldp2_pkg.sv
// Constants and types for the page-2 link diagnostic register bank.
// Assumes a 16-bit management register port with 5-bit register numbers.
package ldp2_pkg;

   // Register port geometry
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam int PAGE_W = 2;
   localparam int LEN_W = 8;
   localparam int OFS_W = 8;

   // Register numbers
   localparam logic [ADDR_W-1:0] PAGE_SEL_ADDR = 5'h13;
   localparam logic [ADDR_W-1:0] ESTIMATED_WIRE_METERS_ADDR = 5'h14;
   localparam logic [ADDR_W-1:0] CLK_OFS_ADDR = 5'h15;

   // Page code that maps the diagnostic registers
   localparam logic [PAGE_W-1:0] DIAG_PAGE = 2'h2;

   // Field positions in the offset sample and length registers
   localparam int TRIG_BIT = 15;
   localparam int SEL_BIT = 8;
   localparam int OFS_LSB = 0;
   localparam int LEN_LSB = 0;

   // Reset values
   localparam logic [PAGE_W-1:0] PAGE_RST = 2'h0;
   localparam logic [LEN_W-1:0] LEN_RST = 8'h00;
   localparam logic [OFS_W-1:0] OFS_RST = 8'h00;
   localparam logic SEL_RST = 1'b0;
   localparam logic [DATA_W-1:0] RDATA_RST = 16'h0000;

   // Code returned when the cable length is unknown
   localparam logic [LEN_W-1:0] LEN_UNKNOWN = 8'hff;

   // Sampler states
   typedef enum logic {
      SMP_IDLE = 1'b0,
      SMP_WAIT = 1'b1
   } ldp2_smp_state_t;

endpackage

// >>> rtl/ldp2_diag_if.sv
// Carrier between the register decoder and its two helper modules.
// Assumes all parties run on the same management clock.
`timescale 1ns/1ps
interface ldp2_diag_if;
   // Sample request and selection from the decoder
   logic trig;
   logic sel;
   // Sampler state and captured value
   logic busy;
   logic [ldp2_pkg::OFS_W-1:0] offset;
   // Cable length as seen by software
   logic [ldp2_pkg::LEN_W-1:0] len;

   modport regs (output trig, output sel, input busy, input offset, input len);
   modport sampler (input trig, input sel, output busy, output offset);
   modport cable (output len);
endinterface

// >>> rtl/ldp2_freq_sampler.sv
// Polls the receive DSP for a frequency offset or control value.
// Assumes the DSP answers a held request with a one-cycle acknowledge.
`timescale 1ns/1ps
module ldp2_freq_sampler (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic arst_n_i,
   // Decoder side
   ldp2_diag_if.sampler dif,
   // DSP poll handshake
   output logic poll_req_o,
   output logic poll_sel_o,
   input wire logic poll_ack_i,
   input wire logic [ldp2_pkg::OFS_W-1:0] poll_data_i
);

   typedef struct packed {
      ldp2_pkg::ldp2_smp_state_t state;
      logic req;
      logic sel;
      logic [ldp2_pkg::OFS_W-1:0] offset;
   } ldp2_smp_t;

   ldp2_smp_t q;
   ldp2_smp_t next_q;

   // Request, wait for acknowledge, capture
   always_comb begin
      next_q = q;
      case (q.state)
         ldp2_pkg::SMP_IDLE: begin
            if (dif.trig) begin
               next_q.req = 1'b1;
               next_q.sel = dif.sel;
               next_q.state = ldp2_pkg::SMP_WAIT;
            end
         end
         ldp2_pkg::SMP_WAIT: begin
            if (poll_ack_i) begin
               next_q.offset = poll_data_i;
               next_q.req = 1'b0;
               next_q.state = ldp2_pkg::SMP_IDLE;
            end
         end
         default: next_q.state = ldp2_pkg::SMP_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q <= '{ldp2_pkg::SMP_IDLE, 1'b0, ldp2_pkg::SEL_RST, ldp2_pkg::OFS_RST};
      end else begin
         q <= next_q;
      end
   end

   assign poll_req_o = q.req;
   assign poll_sel_o = q.sel;
   assign dif.busy = q.req;
   assign dif.offset = q.offset;

   a_poll_start: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (dif.trig && !q.req) |=> (poll_req_o && poll_sel_o == $past(dif.sel)))
      else $error("poll not started with selected source");
   a_ofs_hold: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      !(q.req && poll_ack_i) |=> $stable(dif.offset))
      else $error("offset changed without a sample");
   a_ofs_load: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (q.req && poll_ack_i) |=> (dif.offset == $past(poll_data_i) && !poll_req_o))
      else $error("offset not loaded from DSP answer");
   a_req_held: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (poll_req_o && !poll_ack_i) |=> (poll_req_o && $stable(poll_sel_o)))
      else $error("poll request dropped before acknowledge");

endmodule // ldp2_freq_sampler

// >>> rtl/ldp2_estimated_wire_meters.sv
// Qualifies the cable length estimate for software.
// Assumes speed, link and estimate come from logic on the same clock.
`timescale 1ns/1ps
module ldp2_estimated_wire_meters (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic arst_n_i,
   // Link state and estimator
   input wire logic speed_100_i,
   input wire logic link_ok_i,
   input wire logic len_est_ok_i,
   input wire logic [ldp2_pkg::LEN_W-1:0] len_est_i,
   // Decoder side
   ldp2_diag_if.cable dif
);

   typedef struct packed {
      logic [ldp2_pkg::LEN_W-1:0] len;
   } ldp2_len_t;

   ldp2_len_t q;
   ldp2_len_t next_q;
   logic usable;

   // Estimate only meaningful at 100Mb with link up
   assign usable = speed_100_i && link_ok_i && len_est_ok_i;

   // Pass the estimate or flag it unknown
   always_comb begin
      next_q = q;
      if (usable) begin
         next_q.len = len_est_i;
      end else begin
         next_q.len = ldp2_pkg::LEN_UNKNOWN;
      end
   end

   // Length register
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q <= '{len: ldp2_pkg::LEN_RST};
      end else begin
         q <= next_q;
      end
   end

   assign dif.len = q.len;

   a_len_unknown: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      !usable |=> (dif.len == ldp2_pkg::LEN_UNKNOWN))
      else $error("length not flagged unknown");
   a_len_pass: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      usable |=> (dif.len == $past(len_est_i)))
      else $error("valid estimate not passed through");

endmodule // ldp2_estimated_wire_meters

// >>> rtl/ldp2_link_diag_page2_regs.sv
// Page-2 link diagnostic registers: cable length and clock offset sample.
// Assumes a single-cycle register port with read data one cycle later.
//
// Operation
// - Diagnostic registers visible only on page two
// - Length meaningful only at 100Mb, link up
// - Length in meters, all-ones when unknown
// - Reserved bits ignore writes, read zero
// - Trigger with select clear fetches long-term offset
// - Trigger with select set fetches control value
// - Trigger bit always reads back zero
// - Offset field loads only on a trigger
// - Offset is signed, about 5.1562ppm steps
// - 0x7F max positive, 0x80 max negative
// - Control value includes short-term phase correction
`timescale 1ns/1ps
module ldp2_link_diag_page2_regs (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic arst_n_i,
   // Register port
   input wire logic [ldp2_pkg::ADDR_W-1:0] addr_i,
   input wire logic [ldp2_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [ldp2_pkg::DATA_W-1:0] rdata_o,
   // Link state from the receive path
   input wire logic speed_100_i,
   input wire logic link_ok_i,
   // Cable length estimator
   input wire logic len_est_ok_i,
   input wire logic [ldp2_pkg::LEN_W-1:0] len_est_i,
   // DSP poll handshake
   output logic poll_req_o,
   output logic poll_sel_o,
   input wire logic poll_ack_i,
   input wire logic [ldp2_pkg::OFS_W-1:0] poll_data_i
);

   typedef struct packed {
      logic [ldp2_pkg::PAGE_W-1:0] page;
      logic sel;
      logic trig;
      logic [ldp2_pkg::DATA_W-1:0] rdata;
   } ldp2_regs_t;

   ldp2_regs_t q;
   ldp2_regs_t next_q;
   logic on_diag_page;
   logic [ldp2_pkg::DATA_W-1:0] len_word;
   logic [ldp2_pkg::DATA_W-1:0] ofs_word;
   // Decoded write hits and fields, watched by the checks below
   logic wr_ofs_hit;
   logic wr_trig_hit;
   logic [ldp2_pkg::PAGE_W-1:0] wr_page_code;
   logic wr_sel_bit;

   ldp2_diag_if dif ();

   // Offset sampler
   ldp2_freq_sampler u_sampler (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .dif(dif.sampler),
      .poll_req_o(poll_req_o),
      .poll_sel_o(poll_sel_o),
      .poll_ack_i(poll_ack_i),
      .poll_data_i(poll_data_i)
   );

   // Cable length qualifier
   ldp2_estimated_wire_meters u_cable (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .speed_100_i(speed_100_i),
      .link_ok_i(link_ok_i),
      .len_est_ok_i(len_est_ok_i),
      .len_est_i(len_est_i),
      .dif(dif.cable)
   );

   // Page gate for the diagnostic registers
   assign on_diag_page = (q.page == ldp2_pkg::DIAG_PAGE);

   // Write hits and fields as the checks see them
   assign wr_ofs_hit = wr_i && on_diag_page && (addr_i == ldp2_pkg::CLK_OFS_ADDR);
   assign wr_trig_hit = wr_ofs_hit && wdata_i[ldp2_pkg::TRIG_BIT];
   assign wr_page_code = wdata_i[ldp2_pkg::PAGE_W-1:0];
   assign wr_sel_bit = wdata_i[ldp2_pkg::SEL_BIT];

   // Read words; reserved bits and trigger tied to zero
   always_comb begin
      len_word = '0;
      len_word[ldp2_pkg::LEN_LSB +: ldp2_pkg::LEN_W] = dif.len;
      ofs_word = '0;
      ofs_word[ldp2_pkg::SEL_BIT] = q.sel;
      ofs_word[ldp2_pkg::OFS_LSB +: ldp2_pkg::OFS_W] = dif.offset;
   end

   // Write decode, trigger pulse, read data
   always_comb begin
      next_q = q;
      next_q.trig = 1'b0;
      next_q.rdata = '0;
      if (wr_i) begin
         if (addr_i == ldp2_pkg::PAGE_SEL_ADDR) begin
            next_q.page = wdata_i[ldp2_pkg::PAGE_W-1:0];
         end else if (on_diag_page && addr_i == ldp2_pkg::CLK_OFS_ADDR) begin
            next_q.sel = wdata_i[ldp2_pkg::SEL_BIT];
            next_q.trig = wdata_i[ldp2_pkg::TRIG_BIT];
         end
      end
      if (rd_i) begin
         if (addr_i == ldp2_pkg::PAGE_SEL_ADDR) begin
            next_q.rdata[ldp2_pkg::PAGE_W-1:0] = q.page;
         end else if (on_diag_page && addr_i == ldp2_pkg::ESTIMATED_WIRE_METERS_ADDR) begin
            next_q.rdata = len_word;
         end else if (on_diag_page && addr_i == ldp2_pkg::CLK_OFS_ADDR) begin
            next_q.rdata = ofs_word;
         end
      end
   end

   // State register
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q <= '{ldp2_pkg::PAGE_RST, ldp2_pkg::SEL_RST, 1'b0, ldp2_pkg::RDATA_RST};
      end else begin
         q <= next_q;
      end
   end

   assign dif.trig = q.trig;
   assign dif.sel = q.sel;
   assign rdata_o = q.rdata;

   // Page gate on diagnostic writes and reads
   a_page_gate_wr: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (wr_i && !on_diag_page && addr_i != ldp2_pkg::PAGE_SEL_ADDR) |=> ($stable(q.sel) && !q.trig))
      else $error("diagnostic write taken off page two");

   a_page_gate_rd: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (rd_i && !on_diag_page && addr_i != ldp2_pkg::PAGE_SEL_ADDR) |=> (rdata_o == '0))
      else $error("diagnostic read answered off page two");

   // Page selector stores, holds and reads back its code
   a_page_write: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (wr_i && addr_i == ldp2_pkg::PAGE_SEL_ADDR) |=> (q.page == $past(wr_page_code)))
      else $error("page code not stored");

   a_page_hold: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      !(wr_i && addr_i == ldp2_pkg::PAGE_SEL_ADDR) |=> $stable(q.page))
      else $error("page code changed without a write");

   a_page_read: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (rd_i && addr_i == ldp2_pkg::PAGE_SEL_ADDR)
      |=> (rdata_o[ldp2_pkg::DATA_W-1:ldp2_pkg::PAGE_W] == '0
      && rdata_o[ldp2_pkg::PAGE_W-1:0] == $past(q.page)))
      else $error("page code read back wrong");

   // Length word: reserved bits zero, estimate below
   a_len_read: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (rd_i && on_diag_page && addr_i == ldp2_pkg::ESTIMATED_WIRE_METERS_ADDR)
      |=> (rdata_o[15:8] == 8'h00 && rdata_o[7:0] == $past(dif.len)))
      else $error("length read word wrong");

   // Select bit follows writes to the offset register only
   a_sel_write: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      wr_ofs_hit |=> (q.sel == $past(wr_sel_bit)))
      else $error("select bit not stored");

   a_sel_hold: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      !wr_ofs_hit |=> $stable(q.sel))
      else $error("select bit changed without a write");

   // Trigger is one pulse, and only from a trigger write
   a_trig_pulse: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      wr_trig_hit |=> q.trig)
      else $error("trigger write not taken");

   a_trig_source: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      q.trig |-> $past(wr_trig_hit))
      else $error("trigger without a trigger write");

   a_trig_len_addr: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (wr_i && addr_i == ldp2_pkg::ESTIMATED_WIRE_METERS_ADDR) |=> (!q.trig && $stable(q.sel)))
      else $error("length register write had an effect");

   // Trigger while a poll is pending leaves the source alone
   a_busy_drop: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (q.trig && dif.busy) |=> $stable(poll_sel_o))
      else $error("pending poll source changed");

   // Poll outputs start only from a trigger, with its select
   a_req_from_trig: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      $rose(poll_req_o) |-> $past(q.trig))
      else $error("poll started without a trigger");

   a_req_sel: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      $rose(poll_req_o) |-> (poll_sel_o == $past(q.sel)))
      else $error("poll source differs from select bit");

   a_req_quiet: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      !(q.trig || poll_ack_i) |=> $stable(poll_req_o))
      else $error("poll request moved without trigger or answer");

   // Offset word: trigger and reserved bits zero
   a_trig_zero: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (rd_i && on_diag_page && addr_i == ldp2_pkg::CLK_OFS_ADDR)
      |=> (rdata_o[15:9] == 7'h00 && rdata_o[8] == $past(q.sel)))
      else $error("trigger or reserved bits read nonzero");

   a_ofs_read: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (rd_i && on_diag_page && addr_i == ldp2_pkg::CLK_OFS_ADDR)
      |=> (rdata_o[7:0] == $past(dif.offset)))
      else $error("offset read differs from captured value");

   // Unmapped reads and idle cycles answer zero
   a_unmapped_read: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      (rd_i && addr_i != ldp2_pkg::PAGE_SEL_ADDR && addr_i != ldp2_pkg::ESTIMATED_WIRE_METERS_ADDR
      && addr_i != ldp2_pkg::CLK_OFS_ADDR) |=> (rdata_o == '0))
      else $error("unmapped read answered nonzero");

   a_rdata_idle: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      !rd_i |=> (rdata_o == '0))
      else $error("read data outside read answer");

endmodule // ldp2_link_diag_page2_regs

// >>> sim/ldp2_link_diag_page2_regs_tb.sv
// Self-checking bench for the page-2 link diagnostic register bank.
// Assumes the design package and modules are compiled first; the bench drives all ports.
`timescale 1ns/1ps
module ldp2_link_diag_page2_regs_tb;
   // Clock, reset and register port
   logic mclk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [ldp2_pkg::ADDR_W-1:0] addr_i = 5'h00;
   logic [ldp2_pkg::DATA_W-1:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [ldp2_pkg::DATA_W-1:0] rdata_o;
   // Link state, estimator and DSP side
   logic speed_100_i = 1'b0;
   logic link_ok_i = 1'b0;
   logic len_est_ok_i = 1'b0;
   logic [ldp2_pkg::LEN_W-1:0] len_est_i = 8'h00;
   logic poll_req_o;
   logic poll_sel_o;
   logic poll_ack_i = 1'b0;
   logic [ldp2_pkg::OFS_W-1:0] poll_data_i = 8'h00;
   // Bookkeeping
   int n_errors = 0;
   int comparisons = 0;
   logic [8:0] smp [4] = '{9'h07f, 9'h180, 9'h000, 9'h1c3};

   ldp2_link_diag_page2_regs u_ldp2_link_diag_page2_regs (
      .mclk_i(mclk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .speed_100_i(speed_100_i),
      .link_ok_i(link_ok_i), .len_est_ok_i(len_est_ok_i), .len_est_i(len_est_i),
      .poll_req_o(poll_req_o), .poll_sel_o(poll_sel_o), .poll_ack_i(poll_ack_i),
      .poll_data_i(poll_data_i)
   );

   // Clock at 200 MHz
   always #2.5 mclk_i = ~mclk_i;

   // Compare one value, count and report
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Counts, verdict and end of run
   task automatic stop_test();
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // One-cycle register write
   task automatic wr(input logic [ldp2_pkg::ADDR_W-1:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask

   // One-cycle read, data checked in the following cycle
   task automatic rdc(input logic [ldp2_pkg::ADDR_W-1:0] a, input logic [15:0] e);
      @(posedge mclk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 check(rdata_o, e);
   endtask

   // Trigger a sample and answer it as the DSP
   task automatic poll(input logic s, input logic [7:0] d);
      int k;
      k = 0;
      wr(5'h15, {1'b1, 6'h00, s, 8'h00});
      #1;
      while (poll_req_o !== 1'b1 && k < 20) begin
         @(posedge mclk_i);
         #1;
         k++;
      end
      if (k == 20) begin
         n_errors++;
         stop_test();
      end
      check(16'(poll_sel_o), 16'(s));
      @(posedge mclk_i);
      poll_ack_i <= 1'b1;
      poll_data_i <= d;
      @(posedge mclk_i);
      poll_ack_i <= 1'b0;
      poll_data_i <= ~d;
      #1 check(16'(poll_req_o), 16'h0000);
   endtask

   // Main sequence
   initial begin
      repeat (16) @(posedge mclk_i);
      arst_n_i <= 1'b1;
      // Page zero hides the bank and drops triggers
      rdc(5'h13, 16'h0000);
      rdc(5'h14, 16'h0000);
      wr(5'h15, 16'h8000);
      repeat (4) @(posedge mclk_i);
      #1 check(16'(poll_req_o), 16'h0000);
      // Map page two, offset reads zero from reset
      wr(5'h13, 16'h0002);
      rdc(5'h13, 16'h0002);
      rdc(5'h15, 16'h0000);
      rdc(5'h14, 16'h00ff);
      // Length only with 100Mb, link and estimate all present
      for (int k = 0; k < 4; k++) begin
         @(posedge mclk_i);
         {speed_100_i, link_ok_i, len_est_ok_i} <= 3'b111 ^ 3'(3'b001 << k);
         len_est_i <= 8'(8'h37 + k);
         rdc(5'h14, (k == 3) ? 16'h003a : 16'h00ff);
      end
      // Reserved bits ignore writes and read zero
      wr(5'h14, 16'hffff);
      rdc(5'h14, 16'h003a);
      wr(5'h15, 16'h7fff);
      rdc(5'h15, 16'h0100);
      check(16'(poll_req_o), 16'h0000);
      // Both sources, extreme codes, trigger bit reads zero
      for (int k = 0; k < 4; k++) begin
         poll(smp[k][8], smp[k][7:0]);
         rdc(5'h15, {7'h00, smp[k]});
      end
      // Stray acknowledge leaves the field alone
      @(posedge mclk_i);
      poll_ack_i <= 1'b1;
      poll_data_i <= 8'h55;
      @(posedge mclk_i);
      poll_ack_i <= 1'b0;
      rdc(5'h15, 16'h01c3);
      // Trigger while a poll is pending is dropped
      wr(5'h15, 16'h8000);
      wr(5'h15, 16'h8100);
      #1 check(16'({poll_req_o, poll_sel_o}), 16'h0002);
      @(posedge mclk_i);
      poll_ack_i <= 1'b1;
      poll_data_i <= 8'h11;
      @(posedge mclk_i);
      poll_ack_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      #1 check(16'(poll_req_o), 16'h0000);
      rdc(5'h15, 16'h0111);
      rdc(5'h1f, 16'h0000);
      // Leaving page two hides the bank again
      wr(5'h13, 16'h0001);
      rdc(5'h15, 16'h0000);
      // Second reset clears the sampled field
      @(posedge mclk_i);
      arst_n_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      arst_n_i <= 1'b1;
      wr(5'h13, 16'h0002);
      rdc(5'h15, 16'h0000);
      stop_test();
   end
endmodule // ldp2_link_diag_page2_regs_tb
